// ### dv/serial_flash_erase_powerdown_id_bench.sv
// self-checking bench of the erase, sleep and id sequencer
// assumes the spi host model drives the link at 80 ns per bit
`timescale 1ns/100ps
`include "flash_cfg.svh"

module serial_flash_erase_powerdown_id_bench;
	import flash_pkg::*;
	localparam int          B32 = 2000;
	localparam int          B64 = 300;
	localparam int          BCH = 300;
	// arbitrary identity values
	localparam logic [7:0]  MK  = 8'hc3;
	localparam logic [7:0]  PT  = 8'h2e;
	localparam logic [7:0]  MT  = 8'h71;
	localparam logic [7:0]  CP  = 8'h15;
	localparam logic [127:0] UID = 128'h9e37_79b9_7f4a_7c15_f39c_c060_5ced_c834;

	logic        CLK, RST_N, SCLK, CS_N, SI, SO, SO_OE, OTHER_BUSY;
	logic        BUSY_FLAG, WRITE_ENABLE_LATCH, SLEEPING, ERASE_GO;
	logic [2:0]  PROTECT_BITS;
	erase_req_t  ERASE_REQ, last_req;
	int          mismatches, checked, go_cnt, g0, run, last_len, k;
	logic [31:0] seed, a;
	logic [127:0] rx;

	flash_cmd_seq #(.B32_ERASE_CYC(B32), .B64_ERASE_CYC(B64),
		.CHIP_ERASE_CYC(BCH), .MAKER_ID(MK), .PART_ID(PT),
		.MEM_TYPE(MT), .CAPACITY(CP), .UNIQUE_ID(UID)) u_flash_cmd_seq (
		.CLK(CLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .SI(SI),
		.PROTECT_BITS(PROTECT_BITS), .OTHER_BUSY(OTHER_BUSY), .SO(SO),
		.SO_OE(SO_OE), .BUSY_FLAG(BUSY_FLAG),
		.WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .SLEEPING(SLEEPING),
		.ERASE_GO(ERASE_GO), .ERASE_REQ(ERASE_REQ));
	spi_host_model u_spi_host_model (.SCLK(SCLK), .CS_N(CS_N), .SI(SI),
		.SO(SO), .SO_OE(SO_OE));

	// ==========================================
	// clock, erase pulse and busy length monitors
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		if (ERASE_GO === 1'b1) begin
			go_cnt   <= go_cnt + 1;
			last_req <= ERASE_REQ;
		end
		if (BUSY_FLAG === 1'b1)
			run <= run + 1;
		else if (run != 0) begin
			last_len <= run;
			run      <= 0;
		end
	end

	// ==========================================
	// helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] st(logic [2:0] bp, logic w, logic b);
		return {3'h0, bp, w, b};
	endfunction
	function automatic logic [127:0] ones(int n);
		return ~128'h0 >> (128 - n);
	endfunction
	task automatic chk(input string nm, input logic [127:0] e,
		input logic [127:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] op, input logic [31:0] t,
		input int ns, input int nr, input logic [127:0] e);
		u_spi_host_model.xfer({op, t}, ns, nr, rx);
		chk($sformatf("read %0h", op), e, rx);
	endtask
	task automatic cmd(input logic [7:0] op);
		u_spi_host_model.xfer({op, 32'h0}, 8, 0, rx);
	endtask
	task automatic er(input logic [7:0] op, input logic [23:0] ad,
		input int ns, input logic ok, input erase_kind_t kd,
		input logic [23:0] ex);
		int n;
		g0 = go_cnt;
		u_spi_host_model.xfer({op, ad, 8'h0}, ns, 0, rx);
		for (n = 0; n < 50 && ok && go_cnt == g0; n++)
			@(negedge CLK);
		chk("erase count", g0 + ok, go_cnt);
		if (ok) begin
			chk("kind", kd, last_req.kind);
			if (kd != ERASE_CHIP)
				chk("addr", ex, last_req.addr);
			chk("latch", 0, WRITE_ENABLE_LATCH);
		end
	endtask
	task automatic er_end(input int len);
		int n;
		for (n = 0; n < 3000 && BUSY_FLAG !== 1'b0; n++)
			@(negedge CLK);
		repeat (2) @(negedge CLK);
		chk("busy length", len, last_len);
	endtask
	task automatic summarize();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial begin
		seed = 32'hebf2;
		mismatches = 0; checked = 0; go_cnt = 0; run = 0; last_len = 0;
		PROTECT_BITS = 3'h0; OTHER_BUSY = 1'b0;
		// a clean falling edge on reset also clears the link-side toggle
		RST_N = 1'b1;
		#1 RST_N = 1'b0;
		repeat (12) @(negedge CLK);
		RST_N = 1'b1;
		@(negedge CLK);
		chk("reset", 4'h0, {BUSY_FLAG, WRITE_ENABLE_LATCH, SLEEPING,
			ERASE_GO});
		#1.3;
		for (k = 0; k < 4; k++) begin
			PROTECT_BITS = 3'(rnd());
			rd(8'h05, 0, 8, 8, st(PROTECT_BITS, 0, 0));
		end
		PROTECT_BITS = 3'h0;
		rd(8'h9f, 0, 8, 24, {MK, MT, CP});
		rd(8'h9f, 0, 8, 12, {MK, MT[7:4]});
		chk("so_oe idle", 0, SO_OE);
		rd(8'h90, 0, 32, 32, {MK, PT, MK, PT});
		rd(8'h90, (rnd() << 8) | 32'h0001_0000, 32, 8, ones(8));
		rd(8'hab, 0, 32, 16, {PT, PT});
		rd(8'h4b, 0, 40, 128, UID);
		OTHER_BUSY = 1'b1;
		rd(8'h9f, 0, 8, 24, ones(24));
		rd(8'h05, 0, 8, 8, st(0, 0, 0));
		OTHER_BUSY = 1'b0;
		er(8'h52, 24'h0, 32, 0, ERASE_B32, 0);
		cmd(`OP_WRITE_ENABLE);
		chk("latch set", 1, WRITE_ENABLE_LATCH);
		PROTECT_BITS = 3'h1;
		er(8'h52, 24'h0, 32, 0, ERASE_B32, 0);
		PROTECT_BITS = 3'h0;
		er(8'hd8, 24'h0, 33, 0, ERASE_B64, 0);
		er(8'hd8, 24'h0, 31, 0, ERASE_B64, 0);
		a = rnd();
		er(8'h52, a[23:0], 32, 1, ERASE_B32, {a[23:15], 15'h0});
		rd(8'h05, 0, 8, 8, st(0, 0, 1));
		rd(8'h9f, 0, 8, 24, ones(24));
		cmd(`OP_SLEEP);
		rd(8'hab, 0, 32, 16, ones(16));
		er_end(B32);
		chk("no sleep", 0, SLEEPING);
		cmd(`OP_WRITE_ENABLE);
		a = rnd();
		er(8'hd8, a[23:0], 32, 1, ERASE_B64, {a[23:16], 16'h0});
		er_end(B64);
		for (k = 0; k < 2; k++) begin
			cmd(`OP_WRITE_ENABLE);
			PROTECT_BITS = 3'h4;
			er(k ? 8'hc7 : 8'h60, 0, 8, 0, ERASE_CHIP, 0);
			PROTECT_BITS = 3'h0;
			er(k ? 8'hc7 : 8'h60, 0, 9, 0, ERASE_CHIP, 0);
			er(k ? 8'hc7 : 8'h60, 0, 8, 1, ERASE_CHIP, 0);
			er_end(BCH);
		end
		cmd(`OP_SLEEP);
		repeat (650) @(negedge CLK);
		chk("asleep", 1, SLEEPING);
		rd(8'h05, 0, 8, 8, ones(8));
		cmd(`OP_WRITE_ENABLE);
		chk("latch asleep", 0, WRITE_ENABLE_LATCH);
		OTHER_BUSY = 1'b1;
		cmd(`OP_WAKE_AND_ID);
		chk("wake while busy", 1, SLEEPING);
		OTHER_BUSY = 1'b0;
		cmd(`OP_WAKE_AND_ID);
		repeat (650) @(negedge CLK);
		chk("awake", 0, SLEEPING);
		rd(8'h05, 0, 8, 8, st(0, 0, 0));
		cmd(`OP_SLEEP);
		repeat (650) @(negedge CLK);
		rd(8'hab, 0, 32, 16, {PT, PT});
		repeat (1050) @(negedge CLK);
		chk("awake id", 0, SLEEPING);
		summarize();
	end

	initial begin
		#300000;
		mismatches++;
		summarize();
	end
endmodule

// ### dv/spi_host_model.sv
// host spi master model: drives CS_N, SCLK, SI and samples SO
// assumes a pull-up on the SO line while the flash does not drive it
`timescale 1ns/100ps

module spi_host_model (
	output logic      SCLK,
	output logic      CS_N,
	output logic      SI,
	input  wire logic SO,
	input  wire logic SO_OE
);
	// ==========================================
	// link idles with SCLK low, CS_N high
	initial begin
		SCLK = 1'b0;
		CS_N = 1'b1;
		SI   = 1'b0;
	end

	// ==========================================
	// one frame: nsend bits of tx MSB first, then nread bits back
	task automatic xfer(input logic [39:0] tx, input int nsend,
		input int nread, output logic [127:0] rx);
		int i;
		rx   = '0;
		CS_N = 1'b0;
		for (i = 0; i < nsend + nread; i++) begin
			// inverted filler once the host has released SI
			SI = (i < nsend) ? tx[39 - i] : ~SI;
			#20 SCLK = 1'b1;
			if (i >= nsend)
				rx = {rx[126:0], SO_OE ? SO : 1'b1};
			#40 SCLK = 1'b0;
			#20;
		end
		CS_N = 1'b1;
		SI   = ~SI;
		// gap well above the 3 CLK the core needs to see the rise
		#200;
	endtask
endmodule

// ### hdl/flash_cfg.svh
// opcodes, status layout, bit positions and timing counts of the sequencer
// assumes the core clock runs at CLK_MHZ
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH

`define OP_BLOCK32_ERASE   8'h52
`define OP_BLOCK64_ERASE   8'hd8
`define OP_CHIP_ERASE_A    8'h60
`define OP_CHIP_ERASE_B    8'hc7
`define OP_SLEEP           8'hb9
`define OP_WAKE_AND_ID     8'hab
`define OP_MAKER_PART_ID   8'h90
`define OP_THREE_BYTE_ID   8'h9f
`define OP_UNIQUE_ID       8'h4b
`define OP_STATUS_READ     8'h05
`define OP_WRITE_ENABLE    8'h06
`define OP_WRITE_DISABLE   8'h04

// bit counts in a frame
`define OPCODE_BITS        8'h08
`define ADDR_END_BITS      8'h20
`define UID_START_BITS     8'h28

// status byte positions
`define ST_BUSY            0
`define ST_WEL             1
`define ST_BP_LO           2

`define CLK_MHZ            200
`define SLEEP_ENTRY_NS     3000
`define WAKE_NS            3000
`define WAKE_WITH_ID_NS    5000
// entry is a least time: round up; wake delays are longest: round down
`define SLEEP_ENTRY_CYC    ((`SLEEP_ENTRY_NS * `CLK_MHZ + 999) / 1000)
`define WAKE_CYC           ((`WAKE_NS * `CLK_MHZ) / 1000)
`define WAKE_WITH_ID_CYC   ((`WAKE_WITH_ID_NS * `CLK_MHZ) / 1000)

`endif

// ### hdl/flash_cmd_seq.sv
// erase, deep sleep and identification command handling of a serial flash
// assumes SCLK idles when CS_N is high; SI is sampled on rising SCLK
//
// Function
// - 52h erases 32KB block, D8h 64KB block; any address in block selects it
// - erase starts only with the write enable latch set
// - block erase runs only if CS rises right after the 32nd bit
// - busy flag is 1 for the whole self-timed erase, then 0
// - write enable latch clears before the erase cycle ends
// - block erase into a protected range is ignored
// - 60h or C7h selects chip erase, opcode only
// - chip erase runs only if CS rises right after the 8th bit
// - chip erase runs only when all protect bits are zero
// - B9h alone enters deep sleep after the sleep entry delay
// - in deep sleep every command but ABh is ignored
// - sleep command during a running cycle is rejected
// - ABh alone wakes the device after the wake delay
// - ABh plus three dummy bytes streams the device id repeatedly
// - ABh is ignored while the busy flag is set
// - 90h plus zero address streams maker then device id
// - 9Fh streams maker, memory type and capacity bytes
// - id reads are not decoded during a running cycle
// - CS rising ends any id output, back to standby
// - 4Bh plus zero address and dummy byte streams 128-bit unique id
// - 05h returns the status byte at any time while awake, also during a running cycle
// - all input bits are sampled on rising SCLK
`timescale 1ns/100ps
`include "flash_cfg.svh"

module flash_cmd_seq
	import flash_pkg::*;
#(
	parameter int unsigned      B32_ERASE_CYC  = 32'd100000,
	parameter int unsigned      B64_ERASE_CYC  = 32'd150000,
	parameter int unsigned      CHIP_ERASE_CYC = 32'd800000,
	// arbitrary identity values
	parameter logic [7:0]       MAKER_ID       = 8'h5a,
	parameter logic [7:0]       PART_ID        = 8'h13,
	parameter logic [7:0]       MEM_TYPE       = 8'h40,
	parameter logic [7:0]       CAPACITY       = 8'h13,
	parameter logic [127:0]     UNIQUE_ID      = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210,
	// per protect code: {first 4KB sector, last 4KB sector}, empty if first>last
	parameter logic [7:0][23:0] PROTECT_MAP    = {
		24'h000fff, 24'h000fff, 24'h000fff, 24'h000fff,
		24'h000fff, 24'h000fff, 24'h000fff, 24'hfff000}
) (
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       SCLK,
	input  wire logic       CS_N,
	input  wire logic       SI,
	input  wire logic [2:0] PROTECT_BITS,
	input  wire logic       OTHER_BUSY,
	output logic            SO,
	output logic            SO_OE,
	output logic            BUSY_FLAG,
	output logic            WRITE_ENABLE_LATCH,
	output logic            SLEEPING,
	output logic            ERASE_GO,
	output erase_req_t      ERASE_REQ
);

	// ==========================================================
	// functions
	function automatic logic range_hit(input logic [2:0] bp,
		input logic [11:0] first, input logic [11:0] last);
		logic [11:0] lo;
		logic [11:0] hi;
		lo = PROTECT_MAP[bp][23:12];
		hi = PROTECT_MAP[bp][11:0];
		range_hit = (lo <= hi) && (first <= hi) && (last >= lo);
	endfunction

	function automatic logic id_bit(input logic [7:0] op,
		input logic [7:0] idx, input logic [7:0] st);
		logic [23:0] jid;
		logic [15:0] mp;
		jid = {MAKER_ID, MEM_TYPE, CAPACITY};
		mp  = {MAKER_ID, PART_ID};
		id_bit = 1'b0;
		case (op)
			`OP_STATUS_READ:   id_bit = st[3'd7 - idx[2:0]];
			`OP_WAKE_AND_ID:   id_bit = PART_ID[3'd7 - idx[2:0]];
			`OP_MAKER_PART_ID: id_bit = mp[4'd15 - idx[3:0]];
			`OP_THREE_BYTE_ID: begin
				if (idx < 8'd24) begin
					id_bit = jid[5'd23 - idx[4:0]];
				end
			end
			`OP_UNIQUE_ID: begin
				if (idx < 8'd128) begin
					id_bit = UNIQUE_ID[7'd127 - idx[6:0]];
				end
			end
			default: id_bit = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// link side, SCLK domain
	// core state read by the link side as well
	logic         wel_ff;
	logic         busy_ff;
	sleep_state_t sleep_ff;

	logic        fresh_ff;
	logic        tog_ff;
	logic [7:0]  cnt_ff;
	logic        long_ff;
	logic [7:0]  shin_ff;
	logic [7:0]  opc_ff;
	logic [23:0] addr_ff;
	logic [7:0]  st_l1_ff;
	logic [7:0]  st_l2_ff;
	logic [1:0]  gate_l1_ff;
	logic [1:0]  gate_l2_ff;
	logic [7:0]  nxt_cnt;
	logic [7:0]  out_start;
	logic        nxt_oe;
	logic        nxt_so;
	logic        so_ff;
	logic        so_oe_ff;

	// cs high presets the fresh marker; constant only
	always_ff @(posedge SCLK or posedge CS_N) begin
		if (CS_N) begin
			fresh_ff <= 1'b1;
		end else begin
			fresh_ff <= 1'b0;
		end
	end

	assign nxt_cnt = fresh_ff ? 8'h01 : cnt_ff + 8'h01;

	// frame toggle shares the core reset so both ends start in phase;
	// reset is only released while the link is idle
	always_ff @(posedge SCLK or negedge RST_N) begin
		if (!RST_N) begin
			tog_ff <= 1'b0;
		end else if (fresh_ff) begin
			tog_ff <= ~tog_ff;
		end
	end

	// frame counters and shifters, kept after cs rises for the core side
	always_ff @(posedge SCLK) begin
		cnt_ff  <= nxt_cnt;
		shin_ff <= {shin_ff[6:0], SI};
		if (fresh_ff) begin
			long_ff <= 1'b0;
		end else if (cnt_ff == 8'hff) begin
			long_ff <= 1'b1;
		end
		if (nxt_cnt == `OPCODE_BITS) begin
			opc_ff <= {shin_ff[6:0], SI};
		end
		if (nxt_cnt > `OPCODE_BITS && nxt_cnt <= `ADDR_END_BITS && !long_ff) begin
			addr_ff <= {addr_ff[22:0], SI};
		end
	end

	// status and gate levels into the link domain, two flops each
	always_ff @(posedge SCLK) begin
		st_l1_ff   <= {1'b0, 2'b00, PROTECT_BITS, wel_ff, busy_ff};
		st_l2_ff   <= st_l1_ff;
		gate_l1_ff <= {sleep_ff != AWAKE, busy_ff | OTHER_BUSY};
		gate_l2_ff <= gate_l1_ff;
	end

	always_comb begin
		out_start = 8'hff;
		case (opc_ff)
			`OP_STATUS_READ:   out_start = `OPCODE_BITS;
			`OP_THREE_BYTE_ID: out_start = `OPCODE_BITS;
			`OP_MAKER_PART_ID: out_start = `ADDR_END_BITS;
			`OP_WAKE_AND_ID:   out_start = `ADDR_END_BITS;
			`OP_UNIQUE_ID:     out_start = `UID_START_BITS;
			default:           out_start = 8'hff;
		endcase
		nxt_oe = (cnt_ff >= out_start || long_ff) && out_start != 8'hff;
		// asleep: only the wake command may answer
		if (gate_l2_ff[1] && opc_ff != `OP_WAKE_AND_ID) begin
			nxt_oe = 1'b0;
		end
		// a running cycle blocks every id form but status
		if (gate_l2_ff[0] && opc_ff != `OP_STATUS_READ) begin
			nxt_oe = 1'b0;
		end
		// 90h and 4Bh prefixes need the all-zero address
		if ((opc_ff == `OP_MAKER_PART_ID || opc_ff == `OP_UNIQUE_ID)
			&& addr_ff != 24'h000000) begin
			nxt_oe = 1'b0;
		end
		nxt_so = nxt_oe ?
			id_bit(opc_ff, 8'(cnt_ff - out_start), st_l2_ff) : 1'b0;
	end

	// output shifts on falling SCLK; cs rise drops it at once
	always_ff @(negedge SCLK or posedge CS_N) begin
		if (CS_N) begin
			so_oe_ff <= 1'b0;
			so_ff    <= 1'b0;
		end else begin
			so_oe_ff <= nxt_oe;
			so_ff    <= nxt_so;
		end
	end

	assign SO    = so_ff;
	assign SO_OE = so_oe_ff;

	// ==========================================================
	// core side, CLK domain: frame end detection
	logic        cs_s1_ff;
	logic        cs_s2_ff;
	logic        cs_s3_ff;
	logic        tg_s1_ff;
	logic        tg_s2_ff;
	logic        tg_seen_ff;
	logic        frame_end;
	frame_t      frm;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cs_s1_ff   <= 1'b1;
			cs_s2_ff   <= 1'b1;
			cs_s3_ff   <= 1'b1;
			tg_s1_ff   <= 1'b0;
			tg_s2_ff   <= 1'b0;
			tg_seen_ff <= 1'b0;
		end else begin
			cs_s1_ff <= CS_N;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
			tg_s1_ff <= tog_ff;
			tg_s2_ff <= tg_s1_ff;
			if (frame_end) begin
				tg_seen_ff <= tg_s2_ff;
			end
		end
	end

	// frame words are still once SCLK stopped and cs went high
	assign frame_end = cs_s2_ff && !cs_s3_ff && (tg_s2_ff != tg_seen_ff);
	assign frm       = '{opcode: opc_ff, addr: addr_ff, bits: cnt_ff,
		long_frame: long_ff};

	// ==========================================================
	// command decode
	logic        running;
	logic        exact8;
	logic        exact32;
	logic        go_b32;
	logic        go_b64;
	logic        go_chip;
	logic        go_sleep;
	logic        go_wake;
	logic        go_wake_id;
	logic [11:0] first_sec;

	assign running  = busy_ff || OTHER_BUSY;
	assign exact8   = frm.bits == `OPCODE_BITS && !frm.long_frame;
	assign exact32  = frm.bits == `ADDR_END_BITS && !frm.long_frame;
	assign first_sec = frm.addr[23:12];

	always_comb begin
		go_b32 = frame_end && sleep_ff == AWAKE && !running && wel_ff
			&& frm.opcode == `OP_BLOCK32_ERASE && exact32
			&& !range_hit(PROTECT_BITS, {first_sec[11:3], 3'h0},
				{first_sec[11:3], 3'h7});
		go_b64 = frame_end && sleep_ff == AWAKE && !running && wel_ff
			&& frm.opcode == `OP_BLOCK64_ERASE && exact32
			&& !range_hit(PROTECT_BITS, {first_sec[11:4], 4'h0},
				{first_sec[11:4], 4'hf});
		go_chip = frame_end && sleep_ff == AWAKE && !running && wel_ff
			&& (frm.opcode == `OP_CHIP_ERASE_A
			|| frm.opcode == `OP_CHIP_ERASE_B) && exact8
			&& PROTECT_BITS == 3'h0;
		go_sleep = frame_end && sleep_ff == AWAKE && !running
			&& frm.opcode == `OP_SLEEP && exact8;
		go_wake = frame_end && sleep_ff == ASLEEP && !running
			&& frm.opcode == `OP_WAKE_AND_ID && exact8;
		go_wake_id = frame_end && sleep_ff == ASLEEP && !running
			&& frm.opcode == `OP_WAKE_AND_ID
			&& (frm.bits >= `ADDR_END_BITS || frm.long_frame);
	end

	// ==========================================================
	// write enable latch

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wel_ff <= 1'b0;
		end else if (go_b32 || go_b64 || go_chip) begin
			wel_ff <= 1'b0;
		end else if (frame_end && sleep_ff == AWAKE && exact8 && !running) begin
			if (frm.opcode == `OP_WRITE_ENABLE) begin
				wel_ff <= 1'b1;
			end else if (frm.opcode == `OP_WRITE_DISABLE) begin
				wel_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// self-timed erase
	erase_state_t erase_ff;
	logic [31:0]  erase_cnt_ff;
	logic         go_ff;
	erase_req_t   req_ff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			erase_ff     <= ER_IDLE;
			busy_ff      <= 1'b0;
			erase_cnt_ff <= 32'h0;
		end else begin
			case (erase_ff)
				ER_IDLE: begin
					if (go_b32 || go_b64 || go_chip) begin
						erase_ff     <= ER_RUN;
						busy_ff      <= 1'b1;
						erase_cnt_ff <= go_chip ? CHIP_ERASE_CYC - 32'h1 :
							go_b64 ? B64_ERASE_CYC - 32'h1 : B32_ERASE_CYC - 32'h1;
					end
				end
				ER_RUN: begin
					if (erase_cnt_ff == 32'h0) begin
						erase_ff <= ER_IDLE;
						busy_ff  <= 1'b0;
					end else begin
						erase_cnt_ff <= erase_cnt_ff - 32'h1;
					end
				end
				default: erase_ff <= ER_IDLE;
			endcase
		end
	end

	// block-aligned request toward the array
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			go_ff  <= 1'b0;
			req_ff <= '{kind: ERASE_B32, addr: 24'h0};
		end else begin
			go_ff <= go_b32 || go_b64 || go_chip;
			if (go_b32) begin
				req_ff <= '{kind: ERASE_B32, addr: {frm.addr[23:15], 15'h0}};
			end else if (go_b64) begin
				req_ff <= '{kind: ERASE_B64, addr: {frm.addr[23:16], 16'h0}};
			end else if (go_chip) begin
				req_ff <= '{kind: ERASE_CHIP, addr: 24'h0};
			end
		end
	end

	// ==========================================================
	// deep sleep
	logic [15:0]  sleep_cnt_ff;
	logic         sleeping_ff;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sleep_ff     <= AWAKE;
			sleep_cnt_ff <= 16'h0;
			sleeping_ff  <= 1'b0;
		end else begin
			case (sleep_ff)
				AWAKE: begin
					if (go_sleep) begin
						sleep_ff     <= ENTERING;
						sleep_cnt_ff <= 16'(`SLEEP_ENTRY_CYC - 1);
					end
				end
				ENTERING: begin
					if (sleep_cnt_ff == 16'h0) begin
						sleep_ff    <= ASLEEP;
						sleeping_ff <= 1'b1;
					end else begin
						sleep_cnt_ff <= sleep_cnt_ff - 16'h1;
					end
				end
				ASLEEP: begin
					if (go_wake || go_wake_id) begin
						sleep_ff     <= WAKING;
						sleeping_ff  <= 1'b0;
						sleep_cnt_ff <= go_wake_id ?
							16'(`WAKE_WITH_ID_CYC - 1) : 16'(`WAKE_CYC - 1);
					end
				end
				WAKING: begin
					if (sleep_cnt_ff == 16'h0) begin
						sleep_ff <= AWAKE;
					end else begin
						sleep_cnt_ff <= sleep_cnt_ff - 16'h1;
					end
				end
				default: sleep_ff <= AWAKE;
			endcase
		end
	end

	assign BUSY_FLAG          = busy_ff;
	assign WRITE_ENABLE_LATCH = wel_ff;
	assign SLEEPING           = sleeping_ff;
	assign ERASE_GO           = go_ff;
	assign ERASE_REQ          = req_ff;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_erase_needs_wel: assert property (
		$rose(busy_ff) |-> $past(wel_ff))
		else $error("erase began with latch clear");

	a_wel_drops: assert property (
		$rose(busy_ff) |-> !wel_ff)
		else $error("latch still set during erase");

	a_go_with_busy: assert property (
		go_ff |-> busy_ff && $past(erase_ff) == ER_IDLE)
		else $error("request pulse without busy start");

	a_busy_holds: assert property (
		$fell(busy_ff) |-> $past(erase_cnt_ff) == 32'h0)
		else $error("busy dropped before count end");

	a_chip_unprot: assert property (
		go_ff && req_ff.kind == ERASE_CHIP |-> $past(PROTECT_BITS) == 3'h0)
		else $error("chip erase under protection");

	a_no_sleep_busy: assert property (
		sleep_ff == AWAKE ##1 sleep_ff == ENTERING |-> !$past(busy_ff))
		else $error("sleep taken during a cycle");

	a_asleep_quiet: assert property (
		sleep_ff == ASLEEP |-> ##1 !$rose(busy_ff))
		else $error("erase started while asleep");

	a_sleep_delay: assert property (
		$rose(sleeping_ff) |-> $past(sleep_ff) == ENTERING
			&& $past(sleep_cnt_ff) == 16'h0)
		else $error("sleep entered before delay");

	a_wake_ignored: assert property (
		sleep_ff == ASLEEP && running |=> sleep_ff == ASLEEP)
		else $error("wake accepted while busy");

endmodule

// ### hdl/flash_pkg.sv
// types shared by the erase / sleep / id sequencer
// assumes nothing beyond the cfg header
package flash_pkg;

	typedef enum logic [1:0] {
		ERASE_B32  = 2'b00,
		ERASE_B64  = 2'b01,
		ERASE_CHIP = 2'b10
	} erase_kind_t;

	typedef enum logic [1:0] {
		AWAKE    = 2'b00,
		ENTERING = 2'b01,
		ASLEEP   = 2'b10,
		WAKING   = 2'b11
	} sleep_state_t;

	typedef enum logic {
		ER_IDLE = 1'b0,
		ER_RUN  = 1'b1
	} erase_state_t;

	typedef struct packed {
		erase_kind_t  kind;
		logic [23:0]  addr;
	} erase_req_t;

	typedef struct packed {
		logic [7:0]   opcode;
		logic [23:0]  addr;
		logic [7:0]   bits;
		logic         long_frame;
	} frame_t;

endpackage
